// ===== verilog/iosd_pkg.sv
// Purpose: shared constants and carriers for the terminal status display
// Assumes: 100 MHz core clock, byte addresses on the register port
// Notes: segment bytes are ordered {dp, g, f, e, d, c, b, a}
package iosd_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] IN_WORD_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] OUT_WORD_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] DISPLAY_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] PINS_OFS = 8'h10;

    // ctrl field positions
    localparam int CTRL_HEX_BIT = 0;
    localparam int CTRL_COMM_BIT = 1;
    localparam int CTRL_OUTSEL_BIT = 2;
    localparam int CTRL_INVERT_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // ----------------------------------------------------------------
    // status word bit positions
    // ----------------------------------------------------------------
    localparam int IN_FWD_BIT = 0;
    localparam int IN_REV_BIT = 1;
    localparam int IN_MPA_BIT = 2;
    localparam int IN_MPB_BIT = 3;
    localparam int IN_MPC_BIT = 4;
    localparam int IN_LFWD_BIT = 13;
    localparam int IN_LREV_BIT = 14;
    localparam int IN_LRST_BIT = 15;
    localparam int OUT_TR_BIT = 0;
    localparam int OUT_RELAY_BIT = 8;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // segment positions within a digit byte
    // ----------------------------------------------------------------
    localparam int SEG_A = 0;
    localparam int SEG_B = 1;
    localparam int SEG_C = 2;
    localparam int SEG_D = 3;
    localparam int SEG_E = 4;
    localparam int SEG_F = 5;
    localparam int SEG_G = 6;
    localparam int SEG_DP = 7;
    localparam logic [7:0] SEG_DARK = 8'h00;
    localparam int NUM_DIGITS = 4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = (CLK_FREQ_HZ / 1000) * BLINK_HALF_MS;

    // 1 = terminal shorted to its return / contact closed
    typedef struct packed {
        logic link_reset;
        logic link_reverse;
        logic link_forward;
        logic relay_no;
        logic transistor;
        logic mp_c;
        logic mp_b;
        logic mp_a;
        logic reverse;
        logic forward;
    } iosd_pins_s;

    typedef struct packed {
        logic invert;
        logic out_select;
        logic comm_view;
        logic hex_mode;
    } iosd_ctrl_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr_stb;
        logic rd_stb;
    } iosd_bus_s;

endpackage

// ===== verilog/iosd_hex_seg.sv
// Purpose: one hexadecimal nibble to a seven-segment pattern
// Assumes: segments active high, byte {dp, g, f, e, d, c, b, a}
// Notes: letters b and d in lower case so they differ from 8 and 0
`timescale 1ns/100ps
module iosd_hex_seg (
    input wire logic [3:0] nibble,
    output logic [7:0] seg
);
    import iosd_pkg::*;

    always_comb begin
        case (nibble)
            4'h0: seg = 8'h3F;
            4'h1: seg = 8'h06;
            4'h2: seg = 8'h5B;
            4'h3: seg = 8'h4F;
            4'h4: seg = 8'h66;
            4'h5: seg = 8'h6D;
            4'h6: seg = 8'h7D;
            4'h7: seg = 8'h07;
            4'h8: seg = 8'h7F;
            4'h9: seg = 8'h6F;
            4'hA: seg = 8'h77;
            4'hB: seg = 8'h7C;
            4'hC: seg = 8'h39;
            4'hD: seg = 8'h5E;
            4'hE: seg = 8'h79;
            4'hF: seg = 8'h71;
            default: seg = SEG_DARK;
        endcase
    end

endmodule

// ===== verilog/iosd_top.sv
// Purpose: shows terminal on/off states on a four digit segment monitor
// Assumes: terminal inputs are levels, 1 = shorted to their return
// Notes: two display modes selected from the control register
`timescale 1ns/100ps

// Notes on behaviour
// [RL1] rightmost digit a-e show five inputs
// [RL2] third digit a shows transistor output
// [RL3] leftmost digit a shows relay contact
// [RL4] all inputs open: g blinks everywhere
// [RL5] hex mode: 16-bit word, unused bits zero
// [RL6] input word: forward, reverse, multipurpose bits
// [RL7] output word bit 0: transistor output
// [RL8] output word bit 8: relay contact
// [RL9] bits 15-12 leftmost down to 3-0
// [RL10] link commands at bits 13-15, second digit
// [RL11] link view: active-high only, no inversion
// [RL12] two flip-flop sync on terminal inputs
module iosd_top #(
    parameter int BLINK_HALF_CYCLES = iosd_pkg::BLINK_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run_forward_input,
    input wire logic run_reverse_input,
    input wire logic multipurpose_input_a,
    input wire logic multipurpose_input_b,
    input wire logic multipurpose_input_c,
    input wire logic transistor_output,
    input wire logic relay_normally_open,
    input wire logic link_forward_command,
    input wire logic link_reverse_command,
    input wire logic link_alarm_reset,
    input wire logic [iosd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iosd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    output logic [iosd_pkg::DATA_W-1:0] reg_rdata,
    output logic [7:0] digit_rightmost,
    output logic [7:0] digit_second,
    output logic [7:0] digit_third,
    output logic [7:0] digit_leftmost
);
    import iosd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        iosd_pins_s sync_a;
        iosd_pins_s sync_b;
        iosd_ctrl_s ctrl;
        logic [31:0] blink_cnt;
        logic blink_phase;
        logic [15:0] in_word;
        logic [15:0] out_word;
        logic [NUM_DIGITS-1:0][7:0] segs;
        logic [DATA_W-1:0] rdata;
    } iosd_state_s;

    iosd_state_s st_q;
    iosd_state_s st_d;
    iosd_pins_s pins_raw;
    iosd_pins_s pins_eff;
    iosd_bus_s bus;
    logic [15:0] in_word_c;
    logic [15:0] out_word_c;
    logic [15:0] hex_word;
    logic [NUM_DIGITS-1:0][7:0] hex_segs;
    logic [NUM_DIGITS-1:0][7:0] onoff_segs;
    logic all_open;
    logic blink_tick;

    localparam logic [31:0] BLINK_LAST = 32'(BLINK_HALF_CYCLES - 1);

    // ----------------------------------------------------------------
    // input gathering
    // ----------------------------------------------------------------
    always_comb begin
        pins_raw.forward = run_forward_input;
        pins_raw.reverse = run_reverse_input;
        pins_raw.mp_a = multipurpose_input_a;
        pins_raw.mp_b = multipurpose_input_b;
        pins_raw.mp_c = multipurpose_input_c;
        pins_raw.transistor = transistor_output;
        pins_raw.relay_no = relay_normally_open;
        pins_raw.link_forward = link_forward_command;
        pins_raw.link_reverse = link_reverse_command;
        pins_raw.link_reset = link_alarm_reset;
        bus.addr = reg_addr;
        bus.wdata = reg_wdata;
        bus.wr_stb = reg_wr_stb;
        bus.rd_stb = reg_rd_stb;
    end

    // ----------------------------------------------------------------
    // effective input levels
    // ----------------------------------------------------------------
    // only the second sync stage is looked at from here on
    always_comb begin
        pins_eff = st_q.sync_b; // RL12
        if (st_q.ctrl.invert && !st_q.ctrl.comm_view) begin
            pins_eff.forward = !st_q.sync_b.forward;
            pins_eff.reverse = !st_q.sync_b.reverse;
            pins_eff.mp_a = !st_q.sync_b.mp_a;
            pins_eff.mp_b = !st_q.sync_b.mp_b;
            pins_eff.mp_c = !st_q.sync_b.mp_c;
        end
        // link view never inverts anything
        if (!st_q.ctrl.comm_view) begin // RL11
            pins_eff.link_forward = 1'b0;
            pins_eff.link_reverse = 1'b0;
            pins_eff.link_reset = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // status words
    // ----------------------------------------------------------------
    always_comb begin
        in_word_c = WORD_RESET; // RL5
        in_word_c[IN_FWD_BIT] = pins_eff.forward; // RL6
        in_word_c[IN_REV_BIT] = pins_eff.reverse; // RL6
        in_word_c[IN_MPA_BIT] = pins_eff.mp_a; // RL6
        in_word_c[IN_MPB_BIT] = pins_eff.mp_b; // RL6
        in_word_c[IN_MPC_BIT] = pins_eff.mp_c; // RL6
        in_word_c[IN_LFWD_BIT] = pins_eff.link_forward; // RL10
        in_word_c[IN_LREV_BIT] = pins_eff.link_reverse; // RL10
        in_word_c[IN_LRST_BIT] = pins_eff.link_reset; // RL10
        out_word_c = WORD_RESET; // RL5
        out_word_c[OUT_TR_BIT] = pins_eff.transistor; // RL7
        // open side low: the normally-closed side is then made
        out_word_c[OUT_RELAY_BIT] = pins_eff.relay_no; // RL8
    end

    // ----------------------------------------------------------------
    // blink check and divider
    // ----------------------------------------------------------------
    // link inputs count as inputs only while they are on display
    assign all_open = !(pins_eff.forward || pins_eff.reverse || pins_eff.mp_a
        || pins_eff.mp_b || pins_eff.mp_c || pins_eff.link_forward
        || pins_eff.link_reverse || pins_eff.link_reset);
    assign blink_tick = (st_q.blink_cnt == BLINK_LAST);

    // ----------------------------------------------------------------
    // hexadecimal digits
    // ----------------------------------------------------------------
    // the word on show is the one registered, so the digits lag it a cycle
    assign hex_word = st_q.ctrl.out_select ? st_q.out_word : st_q.in_word;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_digit
            iosd_hex_seg u_hex (
                .nibble(hex_word[gi*4 +: 4]), // RL9
                .seg(hex_segs[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // on/off segment patterns
    // ----------------------------------------------------------------
    always_comb begin
        onoff_segs = '0;
        onoff_segs[0][SEG_A] = pins_eff.forward; // RL1
        onoff_segs[0][SEG_B] = pins_eff.reverse; // RL1
        onoff_segs[0][SEG_C] = pins_eff.mp_a; // RL1
        onoff_segs[0][SEG_D] = pins_eff.mp_b; // RL1
        onoff_segs[0][SEG_E] = pins_eff.mp_c; // RL1
        onoff_segs[1][SEG_F] = pins_eff.link_forward; // RL10
        onoff_segs[1][SEG_G] = pins_eff.link_reverse; // RL10
        onoff_segs[1][SEG_DP] = pins_eff.link_reset; // RL10
        onoff_segs[2][SEG_A] = pins_eff.transistor; // RL2
        onoff_segs[3][SEG_A] = pins_eff.relay_no; // RL3
        if (all_open) begin
            for (int i = 0; i < NUM_DIGITS; i++) begin
                onoff_segs[i][SEG_G] = st_q.blink_phase; // RL4
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sync_a = pins_raw; // RL12
        st_d.sync_b = st_q.sync_a; // RL12
        st_d.in_word = in_word_c;
        st_d.out_word = out_word_c;

        // free running so the blink rate is steady from the first tick
        if (blink_tick) begin
            st_d.blink_cnt = 32'h0000_0000;
            st_d.blink_phase = !st_q.blink_phase; // RL4
        end else begin
            st_d.blink_cnt = st_q.blink_cnt + 32'h0000_0001;
        end

        if (st_q.ctrl.hex_mode) begin
            st_d.segs = hex_segs; // RL5
        end else begin
            st_d.segs = onoff_segs;
        end

        if (bus.wr_stb && bus.addr == CTRL_OFS) begin
            st_d.ctrl.hex_mode = bus.wdata[CTRL_HEX_BIT];
            st_d.ctrl.comm_view = bus.wdata[CTRL_COMM_BIT];
            st_d.ctrl.out_select = bus.wdata[CTRL_OUTSEL_BIT];
            st_d.ctrl.invert = bus.wdata[CTRL_INVERT_BIT];
        end

        // read data stands for one cycle only, unmapped reads give zero
        st_d.rdata = '0;
        if (bus.rd_stb) begin
            case (bus.addr)
                CTRL_OFS: st_d.rdata = {28'h000_0000, st_q.ctrl};
                IN_WORD_OFS: st_d.rdata = {16'h0000, st_q.in_word};
                OUT_WORD_OFS: st_d.rdata = {16'h0000, st_q.out_word};
                DISPLAY_OFS: st_d.rdata = st_q.segs;
                PINS_OFS: st_d.rdata = {22'h00_0000, st_q.sync_b};
                default: st_d.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q.sync_a <= '0;
            st_q.sync_b <= '0;
            st_q.ctrl <= CTRL_RESET;
            st_q.blink_cnt <= 32'h0000_0000;
            st_q.blink_phase <= 1'b0;
            st_q.in_word <= WORD_RESET;
            st_q.out_word <= WORD_RESET;
            st_q.segs <= '0;
            st_q.rdata <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = st_q.rdata;
    assign digit_rightmost = st_q.segs[0];
    assign digit_second = st_q.segs[1];
    assign digit_third = st_q.segs[2];
    assign digit_leftmost = st_q.segs[3];

endmodule

// ===== sim/iosd_properties.sv
// Purpose: port-level checks for the terminal status display
// Assumes: display mode changes only through writes at CTRL_OFS
// Notes: mode is shadowed from bus writes, then seven calm cycles pass
`timescale 1ns/100ps
module iosd_properties #(
    parameter int BLINK_HALF_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run_forward_input,
    input wire logic run_reverse_input,
    input wire logic multipurpose_input_a,
    input wire logic multipurpose_input_b,
    input wire logic multipurpose_input_c,
    input wire logic transistor_output,
    input wire logic relay_normally_open,
    input wire logic link_forward_command,
    input wire logic link_reverse_command,
    input wire logic link_alarm_reset,
    input wire logic [iosd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iosd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [iosd_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [7:0] digit_rightmost,
    input wire logic [7:0] digit_second,
    input wire logic [7:0] digit_third,
    input wire logic [7:0] digit_leftmost
);
    import iosd_pkg::*;
    logic [3:0] ctrl_q;
    logic [2:0] age_q;
    logic rd_in_q;
    logic rd_out_q;
    int lit_q;
    logic [4:0] term;
    logic calm;
    logic on_off;
    logic comm;
    logic inv;
    assign term = {multipurpose_input_c, multipurpose_input_b, multipurpose_input_a,
        run_reverse_input, run_forward_input};
    assign calm = age_q == 3'h7;
    assign on_off = calm && !ctrl_q[CTRL_HEX_BIT];
    assign comm = ctrl_q[CTRL_COMM_BIT];
    assign inv = ctrl_q[CTRL_INVERT_BIT];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // mode shadow; seven cycles covers the three-stage terminal path
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            age_q <= 3'h0;
            rd_in_q <= 1'b0;
            rd_out_q <= 1'b0;
            lit_q <= 0;
        end else begin
            rd_in_q <= reg_rd_stb && reg_addr == IN_WORD_OFS;
            rd_out_q <= reg_rd_stb && reg_addr == OUT_WORD_OFS;
            lit_q <= (on_off && digit_rightmost[SEG_G]) ? lit_q + 1 : 0;
            if (reg_wr_stb && reg_addr == CTRL_OFS) begin
                ctrl_q <= reg_wdata[3:0];
                age_q <= 3'h0;
            end else if (!calm) begin
                age_q <= age_q + 3'h1;
            end
        end
    end

    term_segs_a: assert property (on_off && (!inv || comm) |->
        digit_rightmost[4:0] == $past(term, 3)) else $error("terminal segments wrong");
    invert_segs_a: assert property (on_off && inv && !comm |->
        digit_rightmost[4:0] == ~$past(term, 3)) else $error("inverted segments wrong");
    transistor_seg_a: assert property (on_off |->
        digit_third[0] == $past(transistor_output, 3)) else $error("third digit a wrong");
    relay_seg_a: assert property (on_off |->
        digit_leftmost[0] == $past(relay_normally_open, 3)) else $error("leftmost a wrong");
    blink_same_a: assert property (on_off && !comm |-> digit_third[6] == digit_rightmost[6]
        && digit_leftmost[6] == digit_rightmost[6] && digit_second[6] == digit_rightmost[6])
        else $error("g segments differ");
    blink_quiet_a: assert property (on_off && !comm && !inv && $past(term, 3) != 5'h00
        |-> !digit_rightmost[6]) else $error("g lit with an input active");
    blink_len_a: assert property (lit_q <= BLINK_HALF_CYCLES + 1)
        else $error("g lit too long");
    link_segs_a: assert property (on_off |->
        digit_second[7] == (comm && $past(link_alarm_reset, 3))
        && digit_second[5] == (comm && $past(link_forward_command, 3)))
        else $error("second digit link segments wrong");
    in_gaps_a: assert property (rd_in_q |-> reg_rdata[12:5] == 8'h00
        && reg_rdata[31:16] == 16'h0000) else $error("input word unassigned bit set");
    out_gaps_a: assert property (rd_out_q |->
        (reg_rdata & ~32'h0000_0101) == 32'h0000_0000) else $error("output word stray bit");
endmodule

bind iosd_top iosd_properties #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) i_iosd_properties (
    .core_clk(core_clk), .sys_rst(sys_rst), .run_forward_input(run_forward_input),
    .run_reverse_input(run_reverse_input), .multipurpose_input_a(multipurpose_input_a),
    .multipurpose_input_b(multipurpose_input_b), .multipurpose_input_c(multipurpose_input_c),
    .transistor_output(transistor_output), .relay_normally_open(relay_normally_open),
    .link_forward_command(link_forward_command), .link_alarm_reset(link_alarm_reset),
    .link_reverse_command(link_reverse_command), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
    .digit_rightmost(digit_rightmost), .digit_second(digit_second),
    .digit_third(digit_third), .digit_leftmost(digit_leftmost));

// ===== sim/iosd_terminals.sv
// Purpose: far-side terminals and contacts feeding the display block
// Assumes: the bench names the wanted contact pattern as a pins struct
// Notes: no contact bounce; contacts settle just after a clock edge
`timescale 1ns/100ps
module iosd_terminals (
    input wire logic core_clk,
    input wire iosd_pkg::iosd_pins_s want,
    output iosd_pkg::iosd_pins_s pins
);
    import iosd_pkg::*;
    initial pins = '0;
    always @(posedge core_clk) begin
        pins <= want;
    end
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the terminal status display
// Assumes: blink half period shortened to HALF cycles
// Notes: g is masked in the digit compare while blinking, checked apart
`timescale 1ns/100ps
module tb;
    import iosd_pkg::*;
    localparam int HALF = 8;
    localparam logic [7:0] GLYPH [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d,
        8'h07, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
    logic reg_wr_stb = 1'b0;
    logic reg_rd_stb = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [7:0] dr, d2, d3, dl;
    iosd_pins_s want = '0;
    iosd_pins_s pins;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;

    always #5 core_clk = ~core_clk;

    iosd_terminals i_iosd_terminals (.core_clk(core_clk), .want(want), .pins(pins));
    iosd_top #(.BLINK_HALF_CYCLES(HALF)) i_iosd_top (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .run_forward_input(pins.forward), .run_reverse_input(pins.reverse),
        .multipurpose_input_a(pins.mp_a), .multipurpose_input_b(pins.mp_b),
        .multipurpose_input_c(pins.mp_c), .transistor_output(pins.transistor),
        .relay_normally_open(pins.relay_no), .link_forward_command(pins.link_forward),
        .link_reverse_command(pins.link_reverse), .link_alarm_reset(pins.link_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb),
        .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata), .digit_rightmost(dr),
        .digit_second(d2), .digit_third(d3), .digit_leftmost(dl));

    // ----------------------------------------------------------------
    // shared tasks and the reference model
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_stb <= 1'b1;
        @(posedge core_clk);
        reg_wr_stb <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(string what, logic [7:0] a, logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_stb <= 1'b1;
        @(posedge core_clk);
        reg_rd_stb <= 1'b0;
        #1;
        check(what, reg_rdata, e);
    endtask

    function automatic logic [15:0] in_word(iosd_pins_s p, iosd_ctrl_s c);
        logic [4:0] t;
        t = {p.mp_c, p.mp_b, p.mp_a, p.reverse, p.forward};
        if (c.comm_view) begin
            return {p.link_reset, p.link_reverse, p.link_forward, 8'h00, t};
        end
        return {11'h000, c.invert ? ~t : t};
    endfunction

    task automatic step(iosd_pins_s p, iosd_ctrl_s c);
        logic [15:0] iw;
        logic [15:0] o;
        logic [15:0] h;
        logic [31:0] e;
        logic [31:0] m;
        iw = in_word(p, c);
        o = {7'h00, p.relay_no, 7'h00, p.transistor};
        h = c.out_select ? o : iw;
        // only the on/off view blinks; hex digits keep g fully checked
        m = (iw == 16'h0000 && !c.hex_mode) ? 32'hbfbf_bfbf : 32'hffff_ffff;
        e = {o[15:8], o[7:0], iw[15:13], 5'h00, iw[7:0]};
        if (c.hex_mode) begin
            e = {GLYPH[h[15:12]], GLYPH[h[11:8]], GLYPH[h[7:4]], GLYPH[h[3:0]]};
        end
        wr(CTRL_OFS, {28'h000_0000, c});
        want <= p;
        repeat (8) @(posedge core_clk);
        #1;
        check("digits", {dl, d3, d2, dr} & m, e & m);
        if (iw == 16'h0000 && !c.hex_mode) begin
            check("g lockstep", {29'h0, d3[6], d2[6], dl[6]}, {29'h0, {3{dr[6]}}});
        end
        rd("in word", IN_WORD_OFS, {16'h0000, iw});
        rd("out word", OUT_WORD_OFS, {16'h0000, o});
        rd("ctrl back", CTRL_OFS, {28'h000_0000, c});
        rd("pins", PINS_OFS, {22'h00_0000, p});
        if (m == 32'hffff_ffff) begin
            rd("display", DISPLAY_OFS, e);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        int tg;
        logic g0;
        r = $urandom(32'h0000_e511);
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        wr(IN_WORD_OFS, 32'hffff_ffff);
        wr(8'h14, 32'h0000_000f);
        rd("unmapped", 8'h14, 32'h0000_0000);
        rd("ctrl", CTRL_OFS, 32'h0000_0000);
        rd("in word ro", IN_WORD_OFS, 32'h0000_0000);
        $display("test registers done");
        step(10'h005, 4'h1);
        check("hex 0005", {dl, d3, d2, dr}, 32'h3f3f_3f6d);
        step(10'h060, 4'h5);
        check("hex 0101", {dl, d3, d2, dr}, 32'h3f06_3f06);
        $display("test hex done");
        // relay closed still blinks: only terminal inputs count
        step(10'h040, 4'h0);
        tg = 0;
        g0 = dr[6];
        repeat (2 * HALF + 2) begin
            @(posedge core_clk);
            #1;
            tg += int'(dr[6] !== g0);
            g0 = dr[6];
        end
        check("blink toggles", {31'h0, tg >= 2}, 32'h0000_0001);
        $display("test blink done");
        for (int i = 0; i < 32; i++) begin
            r = $urandom;
            step(r[9:0], i[3:0]);
        end
        $display("test sweep done");
        print_verdict();
    end
endmodule
